// file: hw/amg_decoder.sv
// address map and write guard top: decodes core fetch and data accesses onto
// flash, info page, registers and sram, and blocks application-mode writes to locked sram segments and system registers.
// assumes one access per core-rate enable and a debug port that gates info programming.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module amg_decoder
    import amg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program side request
    input wire logic [amg_pkg::PADDR_W-1:0] p_addr,
    input wire logic p_req,
    // data side request
    input wire logic [amg_pkg::DADDR_W-1:0] d_addr,
    input wire logic d_req,
    input wire logic d_wr,
    input wire logic [amg_pkg::WORD_W-1:0] d_wdata,
    // debug port enable for info page programming, asynchronous pin
    input wire logic serial_debug_port_prog_en,
    // decoded strobes toward memories
    output logic core_tick,
    output logic p_flash_en,
    output logic p_sram_en,
    output logic [amg_pkg::FLASH_WADDR_W-1:0] p_flash_waddr,
    output logic [amg_pkg::SRAM_WADDR_W-1:0] p_sram_waddr,
    output logic d_flash_rd,
    output logic d_flash_wr,
    output logic [amg_pkg::FLASH_WADDR_W-1:0] d_flash_waddr,
    output logic d_info_rd,
    output logic d_info_wr,
    output logic d_reg_rd,
    output logic d_reg_wr,
    output logic d_sram_rd,
    output logic d_sram_wr,
    output logic [amg_pkg::SRAM_WADDR_W-1:0] d_sram_waddr,
    output logic [9:0] d_local_addr,
    output logic [1:0] d_lane_en,
    output logic [amg_pkg::WORD_W-1:0] d_wdata_out,
    output logic d_blocked,
    output logic [amg_pkg::PAGE_IDX_W-1:0] d_flash_page
);
    import amg_pkg::*;
    // ==========================================================
    // core rate enable from ref_clk divider
    logic [3:0] div_reg;
    logic tick;
    // counts ref cycles; 100MHz cannot divide evenly, so rate runs at 11.1MHz worst
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 4'h0;
        end else if (div_reg == 4'(CORE_DIV - 1)) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end
    assign tick = (div_reg == 4'(CORE_DIV - 1)); // [RULE23]
    // ==========================================================
    // pin synchroniser for the debug enable
    logic dbg_s1_reg;
    logic dbg_s2_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_s1_reg <= 1'b0;
            dbg_s2_reg <= 1'b0;
        end else begin
            dbg_s1_reg <= serial_debug_port_prog_en;
            dbg_s2_reg <= dbg_s1_reg;
        end
    end
    // ==========================================================
    // apb registers
    logic [31:0] ctrl_reg;
    logic fault_reg;
    logic ovf_reg;
    logic [1:0] fkind_reg;
    logic [15:0] faddr_reg;
    logic [15:0] fdata_reg;
    logic [31:0] bank_rdata [5];
    logic [4:0] bank_we;
    logic seg_locked;
    logic apb_wr;
    logic apb_rd;
    logic [2:0] win_sect;
    logic app_mode;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign win_sect = ctrl_reg[CTRL_SECT_LSB +: SECTION_W];
    assign app_mode = ctrl_reg[CTRL_APP_BIT];
    // control word: window section and privilege level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (apb_wr && paddr == A_CTRL) begin
            ctrl_reg <= pwdata & 32'h0000_001F; // [RULE7] [RULE21]
        end
    end
    // segment bank write strobes, one per apb word
    genvar g;
    generate
        for (g = 0; g < SEG_REGS; g++) begin : g_we
            assign bank_we[g] = apb_wr && (paddr == A_SEG_BASE + 8'(g * 4));
        end
    endgenerate
    // ==========================================================
    // data side decode, combinational
    logic [14:0] da;
    logic d_byte;
    logic in_win;
    logic in_reg;
    logic in_info;
    logic in_sram;
    logic sys_reg;
    logic [14:0] sram_off;
    logic [SEG_IDX_W-1:0] seg_idx;
    logic blk;
    logic [1:0] blk_kind;
    logic acc;
    assign da = d_addr[14:0]; // [RULE2]
    assign d_byte = d_addr[D_BYTE_FLAG_BIT]; // [RULE4]
    assign in_win = da < D_REG_BASE; // [RULE7]
    assign in_reg = (da >= D_REG_BASE) && (da <= D_REG_END); // [RULE18]
    assign in_info = (da >= D_INFO_BASE) && (da <= D_INFO_END); // [RULE11]
    assign in_sram = da >= D_SRAM_BASE; // [RULE15]
    assign sys_reg = in_reg && da[SYS_REG_OFFSET_BIT];
    assign sram_off = da - D_SRAM_BASE;
    assign seg_idx = SEG_IDX_W'(sram_off[14:5]); // [RULE16]
    assign acc = tick && d_req;
    // block decision; system mode passes every sram and register write
    always_comb begin
        blk = 1'b0;
        blk_kind = FK_SRAM;
        if (d_wr) begin
            if (in_win && d_byte) begin
                blk = 1'b1; // [RULE8]
                blk_kind = FK_FLASH;
            end else if (in_info && (d_byte || !dbg_s2_reg)) begin
                blk = 1'b1; // [RULE12] [RULE13]
                blk_kind = FK_INFO;
            end else if (app_mode && in_sram && seg_locked) begin
                blk = 1'b1; // [RULE16] [RULE17]
                blk_kind = FK_SRAM;
            end else if (app_mode && sys_reg) begin
                blk = 1'b1; // [RULE20] [RULE21]
                blk_kind = FK_SYSREG;
            end
        end
    end
    amg_sram_guard u_guard (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bank_we(bank_we),
        .bank_wdata(pwdata),
        .seg_idx(seg_idx),
        .seg_locked(seg_locked),
        .bank_rdata(bank_rdata)
    );
    // ==========================================================
    // data side strobes, registered; a blocked write raises no write strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            d_flash_rd <= 1'b0;
            d_flash_wr <= 1'b0;
            d_info_rd <= 1'b0;
            d_info_wr <= 1'b0;
            d_reg_rd <= 1'b0;
            d_reg_wr <= 1'b0;
            d_sram_rd <= 1'b0;
            d_sram_wr <= 1'b0;
            d_blocked <= 1'b0;
        end else begin
            d_flash_rd <= acc && !d_wr && in_win;
            d_flash_wr <= acc && d_wr && in_win && !blk; // [RULE8] [RULE24]
            d_info_rd <= acc && !d_wr && in_info;
            d_info_wr <= acc && d_wr && in_info && !blk; // [RULE12] [RULE24]
            d_reg_rd <= acc && !d_wr && in_reg; // [RULE19]
            d_reg_wr <= acc && d_wr && in_reg && !blk; // [RULE24]
            d_sram_rd <= acc && !d_wr && in_sram; // [RULE17]
            d_sram_wr <= acc && d_wr && in_sram && !blk; // [RULE24]
            d_blocked <= acc && blk; // [RULE24]
        end
    end
    // data side addresses and lanes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            d_flash_waddr <= 16'h0000;
            d_sram_waddr <= 12'h000;
            d_local_addr <= 10'h000;
            d_lane_en <= 2'h0;
            d_wdata_out <= 16'h0000;
            d_flash_page <= 7'h00;
        end else if (acc) begin
            d_flash_waddr <= {win_sect, da[13:1]}; // [RULE7] [RULE10]
            d_flash_page <= {win_sect, da[13:10]}; // [RULE9]
            d_sram_waddr <= SRAM_WADDR_W'(sram_off[14:1]);
            d_local_addr <= da[9:0];
            // byte access picks lane from bit zero, word access both lanes
            d_lane_en <= d_byte ? (da[0] ? 2'b10 : 2'b01) : 2'b11; // [RULE25] [RULE3]
            d_wdata_out <= (d_byte && da[0]) ? {d_wdata[7:0], 8'h00} : d_wdata; // [RULE25] [RULE1]
        end
    end
    // ==========================================================
    // program side decode, word addresses only, whole words always
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            p_flash_en <= 1'b0;
            p_sram_en <= 1'b0;
            p_flash_waddr <= 16'h0000;
            p_sram_waddr <= 12'h000;
        end else begin
            // upper flash, including the eeprom section, is not visible here
            p_flash_en <= tick && p_req && (p_addr <= P_FLASH_END); // [RULE5] [RULE10] [RULE6]
            p_sram_en <= tick && p_req && (p_addr >= P_SRAM_BASE); // [RULE14]
            if (tick && p_req) begin
                p_flash_waddr <= p_addr; // [RULE3]
                p_sram_waddr <= SRAM_WADDR_W'(p_addr - P_SRAM_BASE);
            end
        end
    end
    // core rate enable output
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_tick <= 1'b0;
        end else begin
            core_tick <= tick;
        end
    end
    // ==========================================================
    // fault capture; first fault held, later ones set overflow; new fault beats clear
    logic clr_fault;
    assign clr_fault = apb_wr && paddr == A_STATUS && pwdata[ST_FAULT_BIT];
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_reg <= 1'b0;
            ovf_reg <= 1'b0;
            fkind_reg <= FK_SRAM;
            faddr_reg <= 16'h0000;
            fdata_reg <= 16'h0000;
        end else if (acc && blk) begin
            if (fault_reg && !clr_fault) begin
                ovf_reg <= 1'b1; // [RULE22]
            end else begin
                fault_reg <= 1'b1; // [RULE22]
                fkind_reg <= blk_kind;
                faddr_reg <= d_addr;
                fdata_reg <= d_wdata;
                ovf_reg <= clr_fault ? 1'b0 : ovf_reg;
            end
        end else if (clr_fault) begin
            fault_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end
    end
    // ==========================================================
    // apb read data and zero-wait answer
    logic [31:0] rd_mux;
    logic known;
    always_comb begin
        rd_mux = 32'h0000_0000;
        known = 1'b1;
        unique case (paddr)
            A_CTRL: rd_mux = ctrl_reg;
            A_STATUS: rd_mux = {26'h0, fkind_reg, 2'b00, ovf_reg, fault_reg};
            A_FAULT_ADDR: rd_mux = {16'h0000, faddr_reg};
            A_FAULT_DATA: rd_mux = {16'h0000, fdata_reg};
            8'h10: rd_mux = bank_rdata[0];
            8'h14: rd_mux = bank_rdata[1];
            8'h18: rd_mux = bank_rdata[2];
            8'h1C: rd_mux = bank_rdata[3];
            8'h20: rd_mux = bank_rdata[4];
            default: known = 1'b0;
        endcase
    end
    // answer in the access phase: pready rises the cycle after setup
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end
    // ==========================================================
    // assertions
    property p_blk_no_wr;
        @(posedge ref_clk) disable iff (!rst_n)
        (acc && blk) |=> (d_blocked && !d_sram_wr && !d_reg_wr && !d_flash_wr && !d_info_wr);
    endproperty
    a_blk_no_wr: assert property (p_blk_no_wr) else $error("blocked write reached memory"); // [RULE24]
    property p_sys_sram;
        @(posedge ref_clk) disable iff (!rst_n)
        (acc && d_wr && in_sram && !app_mode) |=> d_sram_wr;
    endproperty
    a_sys_sram: assert property (p_sys_sram) else $error("system sram write lost"); // [RULE17]
    property p_lock_sram;
        @(posedge ref_clk) disable iff (!rst_n)
        (acc && d_wr && in_sram && app_mode && seg_locked) |=> (!d_sram_wr && fault_reg);
    endproperty
    a_lock_sram: assert property (p_lock_sram) else $error("locked segment written"); // [RULE16]
    property p_sysreg;
        @(posedge ref_clk) disable iff (!rst_n)
        (acc && d_wr && sys_reg && app_mode) |=> !d_reg_wr;
    endproperty
    a_sysreg: assert property (p_sysreg) else $error("system register written in app mode"); // [RULE20]
    property p_fault_addr;
        @(posedge ref_clk) disable iff (!rst_n)
        (acc && blk && !fault_reg) |=> (faddr_reg == $past(d_addr));
    endproperty
    a_fault_addr: assert property (p_fault_addr) else $error("fault address not captured"); // [RULE22]
    property p_lane;
        @(posedge ref_clk) disable iff (!rst_n)
        (acc && d_byte) |=> (d_lane_en == ($past(da[0]) ? 2'b10 : 2'b01));
    endproperty
    a_lane: assert property (p_lane) else $error("byte lane wrong"); // [RULE25]
    property p_info_dbg;
        @(posedge ref_clk) disable iff (!rst_n)
        d_info_wr |-> $past(dbg_s2_reg);
    endproperty
    a_info_dbg: assert property (p_info_dbg) else $error("info write without debug enable"); // [RULE13]
    property p_pflash;
        @(posedge ref_clk) disable iff (!rst_n)
        p_flash_en |-> $past(p_addr) <= P_FLASH_END;
    endproperty
    a_pflash: assert property (p_pflash) else $error("program flash beyond 56k words"); // [RULE5]
    property p_tick;
        @(posedge ref_clk) disable iff (!rst_n)
        tick |=> !tick [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("core enable spacing wrong"); // [RULE23]
    c_blocked: cover property (@(posedge ref_clk) disable iff (!rst_n) acc && blk && app_mode);
    c_info_wr: cover property (@(posedge ref_clk) disable iff (!rst_n) d_info_wr);
    c_psram: cover property (@(posedge ref_clk) disable iff (!rst_n) p_sram_en);
endmodule // amg_decoder

// file: hw/amg_sram_guard.sv
// sram segment write guard: holds one protection bit per 32-byte segment
// assumes segment bits are loaded over apb by the parent module.
`timescale 1ns/1ps
module amg_sram_guard
    import amg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [4:0] bank_we,
    input wire logic [31:0] bank_wdata,
    input wire logic [amg_pkg::SEG_IDX_W-1:0] seg_idx,
    output logic seg_locked,
    output logic [31:0] bank_rdata [5]
);
    // ==========================================================
    // protection bits, one 32-bit bank per apb word, all writable after reset
    // banks are separate array entries so each generated process owns its own word
    logic [31:0] lock_reg [SEG_REGS];
    genvar b;
    generate
        for (b = 0; b < SEG_REGS; b++) begin : g_bank
            // each apb word holds 32 segment bits
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    lock_reg[b] <= 32'h0000_0000;
                end else if (bank_we[b]) begin
                    lock_reg[b] <= bank_wdata; // [RULE16]
                end
            end
            assign bank_rdata[b] = lock_reg[b];
        end
    endgenerate
    // out-of-range index never locks; upper index bits pick the bank, low five the bit
    assign seg_locked = (seg_idx < SEG_IDX_W'(SEG_COUNT)) ? lock_reg[seg_idx[7:5]][seg_idx[4:0]] : 1'b0; // [RULE16]
endmodule // amg_sram_guard

// file: include/amg_pkg.sv
// address map and write guard: shared constants for the decoder and its sram guard
// assumes a single ref_clk domain, apb register access and a core that issues one
// data access and one fetch per cycle.
//
// Functional notes
// (RULE1) program and data words are sixteen bits
// (RULE2) data address fifteen bits, program sixteen bits
// (RULE3) data byte addresses, program word-only addresses
// (RULE4) data bus bit fifteen marks byte access
// (RULE5) first 112KB flash maps to 56k words
// (RULE6) program flash reads return whole words
// (RULE7) eight 16KB flash sections, one windowed low
// (RULE8) data flash byte reads, whole-word writes only
// (RULE9) flash pages are 1024 bytes for erase
// (RULE10) upper 16KB flash reachable only through window
// (RULE11) info flash page at data byte 0x5000
// (RULE12) info page byte reads, word writes, whole erase
// (RULE13) info page programming enabled only by debug port
// (RULE14) sram on top 2.5k program words
// (RULE15) sram occupies final 5KB of data space
// (RULE16) 32-byte sram segments with per-segment write bit
// (RULE17) sram reads always allowed, system mode writes all
// (RULE18) peripheral registers decoded from data byte 0x4000
// (RULE19) register region accessed only as whole words; the decoder does not refuse byte accesses there
// (RULE20) system registers blocked in application mode
// (RULE21) system mode unrestricted, application mode restricted
// (RULE22) blocked writes captured with details for software
// (RULE23) core and decoder run at 12MHz rate; the divider gives 11.1MHz
// (RULE24) blocked write changes nothing, completes without stall
// (RULE25) byte access address bit zero selects lane
package amg_pkg;
    // ==========================================================
    // widths
    localparam int WORD_W = 16;
    localparam int DADDR_W = 16;
    localparam int PADDR_W = 16;
    localparam int FLASH_WADDR_W = 16;
    localparam int SRAM_WADDR_W = 12;
    localparam int SEG_COUNT = 160;
    localparam int SEG_IDX_W = 8;
    // ==========================================================
    // data space map, byte addresses
    localparam logic [14:0] D_WINDOW_BASE = 15'h0000;
    localparam logic [14:0] D_REG_BASE = 15'h4000;
    localparam logic [14:0] D_REG_END = 15'h4FFF;
    localparam logic [14:0] D_INFO_BASE = 15'h5000;
    localparam logic [14:0] D_INFO_END = 15'h53FF;
    localparam logic [14:0] D_SRAM_BASE = 15'h6C00;
    localparam int D_BYTE_FLAG_BIT = 15;
    localparam int SYS_REG_OFFSET_BIT = 11;
    // ==========================================================
    // program space map, word addresses
    localparam logic [15:0] P_FLASH_END = 16'hDFFF;
    localparam logic [15:0] P_SRAM_BASE = 16'hF600;
    // ==========================================================
    // flash layout
    localparam int SECTION_W = 3;
    localparam logic [2:0] EEPROM_SECT_LO = 3'h7;
    localparam int PAGE_BYTES = 1024;
    localparam int PAGE_IDX_W = 7;
    // ==========================================================
    // apb map, byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_FAULT_ADDR = 8'h08;
    localparam logic [7:0] A_FAULT_DATA = 8'h0C;
    localparam logic [7:0] A_SEG_BASE = 8'h10;
    localparam int SEG_REGS = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_SECT_LSB = 0;
    localparam int CTRL_APP_BIT = 4;
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_OVF_BIT = 1;
    localparam int ST_KIND_LSB = 4;
    // ==========================================================
    // timing
    localparam int CORE_CLK_HZ = 12_000_000;
    localparam int REF_CLK_HZ = 100_000_000;
    localparam int CORE_DIV = (REF_CLK_HZ + CORE_CLK_HZ - 1) / CORE_CLK_HZ;
    // fault kinds
    typedef enum logic [1:0] {
        FK_SRAM = 2'b00,
        FK_SYSREG = 2'b01,
        FK_FLASH = 2'b10,
        FK_INFO = 2'b11
    } amg_fault_type;
endpackage

// file: test/address_map_and_write_guard_bench.sv
// bench for the address map and write guard: apb master, core model, scenario tasks
// assumes amg_core_model beside it and the decoder ports as declared
`timescale 1ns/1ps
module address_map_and_write_guard_bench;
    import amg_pkg::*;
    // ==========================================================
    // stimulus and observed signals, names match the decoder ports
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic serial_debug_port_prog_en = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, p_req, d_req, d_wr, core_tick, p_flash_en, p_sram_en;
    logic d_flash_rd, d_flash_wr, d_info_rd, d_info_wr, d_reg_rd, d_reg_wr, d_sram_rd, d_sram_wr, d_blocked;
    logic [15:0] p_addr, d_addr, d_wdata, p_flash_waddr, d_flash_waddr, d_wdata_out;
    logic [11:0] p_sram_waddr, d_sram_waddr;
    logic [9:0] d_local_addr;
    logic [1:0] d_lane_en;
    logic [6:0] d_flash_page;
    // strobes bundled for the model, one bit each
    wire [8:0] d_hit = {d_flash_rd, d_flash_wr, d_info_rd, d_info_wr, d_reg_rd, d_reg_wr, d_sram_rd, d_sram_wr, d_blocked};
    wire [1:0] p_hit = {p_flash_en, p_sram_en};
    int bad_count = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic err;
    logic [8:0] h;
    logic [1:0] ph;
    always #5 ref_clk = ~ref_clk;
    amg_decoder amg_decoder_i (.*);
    amg_core_model amg_core_model_i (.*);
    // ==========================================================
    // shared compare, apb cycle and core access
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // setup then access; nothing released before pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic dacc(input logic [15:0] a, input logic w, input logic [15:0] wd, input logic [8:0] eh);
        amg_core_model_i.data_acc(a, w, wd, h);
        check("d_hit", h, eh);
    endtask
    // fault flag and kind, then write one to clear
    task automatic fault(input logic [31:0] exp);
        apb(1'b0, A_STATUS, 32'h0);
        check("status", rd & 32'h33, exp);
        apb(1'b1, A_STATUS, 32'h1);
        apb(1'b0, A_STATUS, 32'h0);
        check("cleared", rd & 32'h3, 32'h0);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        apb(1'b0, A_CTRL, 32'h0);
        check("ctrl", rd, CTRL_RESET);
        apb(1'b0, 8'h40, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        apb(1'b1, A_SEG_BASE, 32'h1);
        apb(1'b0, A_SEG_BASE, 32'h0);
        check("seg", rd, 32'h1);
    endtask
    task automatic t_tick();
        int n;
        n = 0;
        do @(posedge ref_clk); while (core_tick !== 1'b1);
        do begin @(posedge ref_clk); n++; end while (core_tick !== 1'b1);
        check("tick", n, CORE_DIV);
    endtask
    task automatic t_prog();
        amg_core_model_i.fetch(16'hDFFF, ph);
        check("p_hit", ph, 2'b10);
        check("pfa", p_flash_waddr, 16'hDFFF);
        amg_core_model_i.fetch(16'hF600, ph);
        check("p_hit", ph, 2'b01);
        check("psa", p_sram_waddr, 12'h000);
        amg_core_model_i.fetch(16'hFFFF, ph);
        check("psa", p_sram_waddr, 12'h9FF);
    endtask
    task automatic t_window();
        apb(1'b1, A_CTRL, 32'h5);
        dacc(16'h8D23, 1'b0, 16'h0, 9'h100);
        check("dfa", d_flash_waddr, 16'hA691);
        check("page", d_flash_page, 7'h53);
        check("lane", d_lane_en, 2'b10);
        apb(1'b1, A_CTRL, 32'h7);
        dacc(16'h3FFE, 1'b1, 16'h1234, 9'h080);
        check("dfa", d_flash_waddr, 16'hFFFF);
        check("wdata", d_wdata_out, 16'h1234);
        check("lane", d_lane_en, 2'b11);
        dacc(16'h8010, 1'b1, 16'h0055, 9'h001);
        fault(32'h21);
    endtask
    task automatic t_info();
        dacc(16'hD001, 1'b0, 16'h0, 9'h040);
        check("local", d_local_addr, 10'h001);
        dacc(16'h5002, 1'b1, 16'h0F0F, 9'h001);
        fault(32'h31);
        serial_debug_port_prog_en <= 1'b1;
        repeat (4) @(posedge ref_clk);
        dacc(16'h5002, 1'b1, 16'h0F0F, 9'h020);
        check("local", d_local_addr, 10'h002);
        dacc(16'hD003, 1'b1, 16'h0011, 9'h001);
        fault(32'h31);
        serial_debug_port_prog_en <= 1'b0;
    endtask
    // register region reached with word accesses only
    task automatic t_sysreg();
        apb(1'b1, A_CTRL, 32'h10);
        dacc(16'h4000, 1'b1, 16'h1111, 9'h008);
        dacc(16'h4802, 1'b1, 16'hBEEF, 9'h001);
        apb(1'b0, A_FAULT_ADDR, 32'h0);
        check("faddr", rd, 32'h4802);
        apb(1'b0, A_FAULT_DATA, 32'h0);
        check("fdata", rd, 32'hBEEF);
        fault(32'h11);
        apb(1'b1, A_CTRL, 32'h0);
        dacc(16'h4802, 1'b1, 16'hBEEF, 9'h008);
        dacc(16'h4802, 1'b0, 16'h0, 9'h010);
    endtask
    task automatic t_sram();
        apb(1'b1, A_CTRL, 32'h10);
        dacc(16'h6C00, 1'b1, 16'h2222, 9'h001);
        fault(32'h01);
        // two refusals in a row: first one held, second raises overflow
        dacc(16'h6C02, 1'b1, 16'h4444, 9'h001);
        dacc(16'h6C04, 1'b1, 16'h5555, 9'h001);
        apb(1'b0, A_FAULT_ADDR, 32'h0);
        check("faddr", rd, 32'h6C02);
        fault(32'h03);
        dacc(16'h6C00, 1'b0, 16'h0, 9'h004);
        dacc(16'hEC21, 1'b1, 16'h00AB, 9'h002);
        check("swa", d_sram_waddr, 12'h010);
        check("lane", d_lane_en, 2'b10);
        check("hibyte", d_wdata_out[15:8], 8'hAB);
        dacc(16'h7FFE, 1'b1, 16'h3333, 9'h002);
        check("swa", d_sram_waddr, 12'h9FF);
        apb(1'b1, A_CTRL, 32'h0);
        dacc(16'h6C00, 1'b1, 16'h2222, 9'h002);
    endtask
    // ==========================================================
    // verdict, reached from the main sequence or the watchdog
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_tick();
        t_prog();
        t_window();
        t_info();
        t_sysreg();
        t_sram();
        end_sim();
    end
    // watchdog: the whole run needs well under a tenth of this span
    initial begin
        #500000;
        bad_count++;
        end_sim();
    end
endmodule // address_map_and_write_guard_bench

// file: test/amg_core_model.sv
// core model: one program fetch or data access at a time toward the decoder
// assumes callers start just after a rising edge of ref_clk
`timescale 1ns/1ps
module amg_core_model
    import amg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [8:0] d_hit,
    input wire logic [1:0] p_hit,
    output logic [amg_pkg::PADDR_W-1:0] p_addr = 16'h0000,
    output logic p_req = 1'b0,
    output logic [amg_pkg::DADDR_W-1:0] d_addr = 16'h0000,
    output logic d_req = 1'b0,
    output logic d_wr = 1'b0,
    output logic [amg_pkg::WORD_W-1:0] d_wdata = 16'h0000
);
    // ==========================================================
    // fetch: program addresses are whole words only
    task automatic fetch(input logic [15:0] a, output logic [1:0] hit);
        @(posedge ref_clk);
        p_addr <= a;
        p_req <= 1'b1;
        hit = 2'b00;
        // hold until a strobe answers, bounded so a dead decoder shows up
        for (int n = 0; n < 40 && hit == 2'b00; n++) begin
            @(posedge ref_clk);
            hit = p_hit;
        end
        // released lines show the inverse, never a stale copy
        p_req <= 1'b0;
        p_addr <= ~a;
    endtask
    // ==========================================================
    // data access: request held until a strobe or a refusal pulse
    task automatic data_acc(input logic [15:0] a, input logic w, input logic [15:0] wd, output logic [8:0] hit);
        @(posedge ref_clk);
        d_addr <= a;
        d_wr <= w;
        d_wdata <= wd;
        d_req <= 1'b1;
        hit = 9'h000;
        for (int n = 0; n < 40 && hit == 9'h000; n++) begin
            @(posedge ref_clk);
            hit = d_hit;
        end
        d_req <= 1'b0;
        d_addr <= ~a;
        d_wr <= ~w;
        d_wdata <= ~wd;
    endtask
endmodule // amg_core_model
